// [design/sgte_eval.v]
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sgte_map.vh"


module sgte_eval #(
	parameter CODE_W        = 8,
	parameter READY_CYC     = `SGTE_READY_MS * `SGTE_CYC_PER_MS,
	parameter TEACH_CYC     = `SGTE_TEACH_MS * `SGTE_CYC_PER_MS,
	parameter START_CYC     = `SGTE_START_MS * `SGTE_CYC_PER_MS,
	parameter SETTLE_CYC    = `SGTE_SETTLE_MS * `SGTE_CYC_PER_MS,
	parameter FAST_HALF_CYC = `SGTE_FAST_HALF_NS / `SGTE_CLK_NS,
	parameter TICK_CYC      = `SGTE_TICK_MS * `SGTE_CYC_PER_MS
) (
	// Clock and reset
	input  wire                ref_clk,
	input  wire                reset,
	// AHB-Lite slave
	input  wire                hsel,
	input  wire [31:0]         haddr,
	input  wire [1:0]          htrans,
	input  wire                hwrite,
	input  wire [2:0]          hsize,
	input  wire [31:0]         hwdata,
	input  wire                hready,
	output reg  [31:0]         hrdata,
	output wire                hreadyout,
	output wire                hresp,
	// Terminals and switches
	output wire                teachJumperA,
	input  wire                teachJumperB,
	input  wire [5:0]          dipSwitch,
	input  wire                startButton,
	input  wire                functionTestInput,
	output wire                feedbackLoopA,
	input  wire                feedbackLoopB,
	input  wire [1:0]          relayContactOpen,
	// Read heads
	input  wire [3:0]          headPresent,
	input  wire [4*CODE_W-1:0] headCode,
	output reg  [3:0]          headActivate,
	input  wire                internalFault,
	// Safety and monitoring outputs
	output reg                 relayA,
	output reg                 relayB,
	output wire                enableOutput,
	output wire                diagnosticOutput,
	// Indicators
	output wire                ledState,
	output wire                ledOut,
	output wire                ledDia
);

	localparam ST_BOOT  = 3'h0;
	localparam ST_TEACH = 3'h1;
	localparam ST_TSAVE = 3'h2;
	localparam ST_TDONE = 3'h3;
	localparam ST_RUN   = 3'h4;
	localparam ST_FCFG  = 3'h5;
	localparam ST_FFB   = 3'h6;
	localparam ST_FINT  = 3'h7;
	localparam PIN_W    = 16;

	// ------------------------------------------------------------
	// Pin synchronisers: a change counts once stages two and three agree
	// ------------------------------------------------------------
	wire [PIN_W-1:0] pinRaw = {teachJumperB, dipSwitch, startButton, functionTestInput,
	                           feedbackLoopB, headPresent, relayContactOpen};
	reg  [PIN_W-1:0] s1;
	reg  [PIN_W-1:0] s2;
	reg  [PIN_W-1:0] s3;
	reg  [PIN_W-1:0] pin;

	always @(posedge ref_clk) begin
		if (reset) begin
			s1  <= {PIN_W{1'b0}};
			s2  <= {PIN_W{1'b0}};
			s3  <= {PIN_W{1'b0}};
			pin <= {PIN_W{1'b0}};
		end else begin
			s1  <= pinRaw;
			s2  <= s1;
			s3  <= s2;
			pin <= (s2 & s3) | (pin & (s2 | s3));
		end
	end

	wire       jumperIn    = pin[15];
	wire [5:0] dip         = pin[14:9];
	wire       startIn     = pin[8];
	wire       testIn      = pin[7];
	wire       loopIn      = pin[6];
	wire [3:0] present     = pin[5:2];
	wire [1:0] contactOpen = pin[1:0];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [2:0]          state;
	reg  [31:0]         cnt;
	reg  [7:0]          cfgWord;
	reg  [4*CODE_W-1:0] taught;
	reg  [3:0]          capPresent;
	reg  [2:0]          loadIdx;
	reg  [31:0]         startCnt;
	reg                 startOk;
	reg  [31:0]         offCnt;
	reg                 forceOff;
	reg  [3:0]          detected;
	integer             k;

	wire [3:0] cfgHeads  = cfgWord[`SGTE_CFG_HEADS +: 4];
	wire       cfgManual = cfgWord[`SGTE_CFG_MANUAL];
	wire       cfgFb     = cfgWord[`SGTE_CFG_FB];

	// A head only counts when its own taught actuator is in range
	always @* begin
		for (k = 0; k < 4; k = k + 1) begin
			detected[k] = present[k] && (headCode[k*CODE_W +: CODE_W] == taught[k*CODE_W +: CODE_W]);
		end
	end

	wire guardOk  = ((detected | ~cfgHeads) == 4'hf) && (cfgHeads != 4'h0);
	wire relayOn  = relayA;
	wire settled  = (offCnt == SETTLE_CYC);
	// Contacts are only checked once the outputs have dropped, so a weld shows at the next opening
	wire weldBad  = settled && (contactOpen != 2'h3);
	wire intFault = internalFault | weldBad;
	wire fbBad    = cfgFb && settled && !loopIn;

	// Teach entry checks the setup the operator prepared
	wire teachBad = (dip[3:0] != present) || (dip[3:0] == 4'h0) ||
	                (dip[4] && !startIn) || (dip[5] && !loopIn);
	// Normal boot compares switches and inputs with what was taught
	wire bootBad  = cfgWord[`SGTE_CFG_MARK] || !cfgWord[`SGTE_CFG_VALID] ||
	                (dip != cfgWord[5:0]) || (cfgHeads == 4'h0) ||
	                (!cfgManual && startIn) || (!cfgFb && loopIn);

	wire [7:0] teachWord = {1'b0, 1'b1, dip};

	// ------------------------------------------------------------
	// Non-volatile configuration store
	// ------------------------------------------------------------
	wire [2:0]        nvRdAddr = cnt[2:0];
	wire [CODE_W-1:0] nvRd;
	reg               nvWe;
	reg  [2:0]        nvWrAddr;
	reg  [CODE_W-1:0] nvWrData;

	always @* begin
		nvWe     = 1'b0;
		nvWrAddr = `SGTE_NV_CFG;
		nvWrData = {CODE_W{1'b0}};
		if (state == ST_TEACH && cnt == 32'h0) begin
			// In-progress mark: a power loss before saving shows at the next boot
			nvWe                     = 1'b1;
			nvWrData[`SGTE_CFG_MARK] = 1'b1;
		end else if (state == ST_TSAVE) begin
			nvWe = 1'b1;
			if (cnt[2:0] == 3'h4) begin
				nvWrData[7:0] = cfgWord;
			end else begin
				nvWrAddr = cnt[2:0] + 3'h1;
				nvWrData = taught[cnt[1:0]*CODE_W +: CODE_W];
			end
		end
	end

	sgte_nvmem #(
		.W  (CODE_W),
		.AW (3)
	) u_nvmem (
		.ref_clk (ref_clk),
		.we      (nvWe),
		.wrAddr  (nvWrAddr),
		.wrData  (nvWrData),
		.rdAddr  (nvRdAddr),
		.rdData  (nvRd)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (reset) begin
			state      <= ST_BOOT;
			cnt        <= 32'h0;
			cfgWord    <= 8'h00;
			taught     <= {4*CODE_W{1'b0}};
			capPresent <= 4'h0;
			loadIdx    <= 3'h0;
		end else begin
			loadIdx <= nvRdAddr;
			cnt     <= cnt + 32'h1;
			if (state == ST_BOOT && cnt >= 32'h1 && cnt <= 32'h5) begin
				if (loadIdx == `SGTE_NV_CFG) begin
					cfgWord <= nvRd[7:0];
				end else begin
					taught[(loadIdx - 3'h1)*CODE_W +: CODE_W] <= nvRd;
				end
			end
			case (state)
				ST_BOOT: begin
					if (cnt == READY_CYC - 1) begin
						cnt <= 32'h0;
						if (jumperIn) begin
							state <= ST_TEACH;
						end else if (bootBad) begin
							state <= ST_FCFG;
						end else begin
							state <= ST_RUN;
						end
					end
				end
				ST_TEACH: begin
					if (cnt == 32'h0) begin
						capPresent <= present;
						cfgWord    <= teachWord;
						if (teachBad) begin
							state <= ST_FCFG;
						end
					end else if (present != capPresent || dip != cfgWord[5:0]) begin
						state <= ST_FCFG;
					end else if (cnt == TEACH_CYC - 1) begin
						// Codes taken late: heads only answer once they have been powered up
						taught <= headCode;
						cnt    <= 32'h0;
						state  <= ST_TSAVE;
					end
				end
				ST_TSAVE: begin
					if (cnt == 32'h4) begin
						state <= ST_TDONE;
					end
				end
				ST_RUN: begin
					// Switches moved or jumper fitted while powered
					if (dip != cfgWord[5:0] || jumperIn) begin
						state <= ST_FCFG;
					end else if (fbBad) begin
						state <= ST_FFB;
					end
				end
				default: begin
				end
			endcase
			// Faults latch until power is removed
			if (intFault && state != ST_FINT) begin
				state <= ST_FINT;
			end
		end
	end

	// ------------------------------------------------------------
	// Start button, settle timer and relays
	// ------------------------------------------------------------
	wire canClose = (state == ST_RUN) && guardOk && !testIn && !forceOff && !intFault &&
	                (dip == cfgWord[5:0]) && !jumperIn && !fbBad;

	always @(posedge ref_clk) begin
		if (reset) begin
			startCnt <= 32'h0;
			startOk  <= 1'b0;
			offCnt   <= 32'h0;
			relayA   <= 1'b0;
			relayB   <= 1'b0;
		end else begin
			startCnt <= startIn ? ((startCnt == START_CYC) ? startCnt : startCnt + 32'h1) : 32'h0;
			if (!guardOk || testIn || state != ST_RUN) begin
				startOk <= 1'b0;
			end else if (startCnt == START_CYC && !relayOn) begin
				startOk <= 1'b1;
			end
			offCnt <= relayOn ? 32'h0 : ((offCnt == SETTLE_CYC) ? offCnt : offCnt + 32'h1);
			// Feedback mode waits for the loop to close before closing the outputs
			if (canClose && (!cfgManual || startOk) && (!cfgFb || relayOn || loopIn)) begin
				relayA <= 1'b1;
				relayB <= 1'b1;
			end else begin
				relayA <= 1'b0;
				relayB <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Heads, monitoring outputs and indicators
	// ------------------------------------------------------------
	reg [2:0] ledMode;

	always @(posedge ref_clk) begin
		if (reset) begin
			headActivate <= 4'h0;
		end else if (state == ST_TEACH) begin
			headActivate <= 4'hf;
		end else if (state == ST_RUN) begin
			headActivate <= cfgHeads;
		end else begin
			headActivate <= 4'h0;
		end
	end

	always @* begin
		case (state)
			ST_BOOT:  ledMode = `SGTE_LED_FAST;
			ST_TEACH: ledMode = `SGTE_LED_SLOW;
			ST_TSAVE: ledMode = `SGTE_LED_SLOW;
			ST_RUN:   ledMode = `SGTE_LED_ON;
			ST_FCFG:  ledMode = `SGTE_LED_BURST3;
			ST_FFB:   ledMode = `SGTE_LED_BURST4;
			default:  ledMode = `SGTE_LED_OFF;
		endcase
	end

	sgte_flasher #(
		.FAST_HALF_CYC (FAST_HALF_CYC),
		.TICK_CYC      (TICK_CYC)
	) u_flasher (
		.ref_clk (ref_clk),
		.reset   (reset),
		.mode    (ledMode),
		.led     (ledState)
	);

	wire faultSt = (state == ST_FCFG) || (state == ST_FFB) || (state == ST_FINT);
	wire diagOn  = faultSt || (testIn && state == ST_RUN);

	assign teachJumperA     = 1'b1;
	assign feedbackLoopA    = 1'b1;
	assign enableOutput     = relayA;
	assign ledOut           = relayA;
	assign ledDia           = diagOn;
	assign diagnosticOutput = diagOn;

	// ------------------------------------------------------------
	// AHB-Lite slave: zero wait states, always OKAY
	// ------------------------------------------------------------
	wire       access = hsel && htrans[1] && hready;
	reg        wrPend;
	reg  [7:0] wrAddr;

	function [31:0] readReg;
		input [7:0] a;
		begin
			readReg = 32'h0;
			case (a)
				`SGTE_OFS_CTRL:   readReg[`SGTE_CTRL_FORCE] = forceOff;
				`SGTE_OFS_STATUS: begin
					readReg[`SGTE_ST_STATE +: 3]   = state;
					readReg[`SGTE_ST_RELAY]        = relayA;
					readReg[`SGTE_ST_DIAG]         = diagOn;
					readReg[`SGTE_ST_TEST]         = testIn;
					readReg[`SGTE_ST_START]        = startOk;
					readReg[`SGTE_ST_GUARD]        = guardOk;
					readReg[`SGTE_ST_PRESENT +: 4] = detected;
				end
				`SGTE_OFS_CONFIG: readReg[7:0] = cfgWord;
				default:          readReg = 32'h0;
			endcase
		end
	endfunction

	always @(posedge ref_clk) begin
		if (reset) begin
			wrPend   <= 1'b0;
			wrAddr   <= 8'h00;
			hrdata   <= 32'h0;
			forceOff <= `SGTE_CTRL_RESET;
		end else begin
			if (hready) begin
				wrPend <= access && hwrite;
				wrAddr <= haddr[7:0];
			end
			if (access && !hwrite) begin
				hrdata <= readReg(haddr[7:0]);
			end
			if (wrPend && wrAddr == `SGTE_OFS_CTRL) begin
				forceOff <= hwdata[`SGTE_CTRL_FORCE];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule // sgte_eval

// [shared/sgte_map.vh]
`ifndef SGTE_MAP_VH
`define SGTE_MAP_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SGTE_CLK_NS       5
`define SGTE_CYC_PER_MS   (1000000 / `SGTE_CLK_NS)
`define SGTE_READY_MS     10000
`define SGTE_TEACH_MS     10000
`define SGTE_START_MS     250
`define SGTE_SETTLE_MS    20
`define SGTE_FAST_HZ      15
`define SGTE_TICK_MS      50
`define SGTE_TICKS_PER_S  20
`define SGTE_FAST_HALF_NS (1000000000 / (2 * `SGTE_FAST_HZ))

// ------------------------------------------------------------
// Register map (byte offsets) and fields
// ------------------------------------------------------------
`define SGTE_OFS_CTRL     8'h00
`define SGTE_OFS_STATUS   8'h04
`define SGTE_OFS_CONFIG   8'h08
`define SGTE_CTRL_FORCE   0
`define SGTE_CTRL_RESET   1'h0
`define SGTE_ST_STATE     0
`define SGTE_ST_RELAY     3
`define SGTE_ST_DIAG      4
`define SGTE_ST_TEST      5
`define SGTE_ST_START     6
`define SGTE_ST_GUARD     7
`define SGTE_ST_PRESENT   8

// ------------------------------------------------------------
// Stored configuration word
// ------------------------------------------------------------
`define SGTE_CFG_HEADS    0
`define SGTE_CFG_MANUAL   4
`define SGTE_CFG_FB       5
`define SGTE_CFG_VALID    6
`define SGTE_CFG_MARK     7
`define SGTE_NV_CFG       3'h0

// ------------------------------------------------------------
// Indicator patterns
// ------------------------------------------------------------
`define SGTE_LED_OFF      3'h0
`define SGTE_LED_ON       3'h1
`define SGTE_LED_FAST     3'h2
`define SGTE_LED_SLOW     3'h3
`define SGTE_LED_BURST3   3'h4
`define SGTE_LED_BURST4   3'h5

`endif

// [design/sgte_nvmem.v]
`timescale 1ns/1ps

module sgte_nvmem #(
	parameter W  = 8,
	parameter AW = 3
) (
	// Clock
	input  wire          ref_clk,
	// Write port
	input  wire          we,
	input  wire [AW-1:0] wrAddr,
	input  wire [W-1:0]  wrData,
	// Read port
	input  wire [AW-1:0] rdAddr,
	output reg  [W-1:0]  rdData
);

	reg [W-1:0] mem [0:(1<<AW)-1];
	integer     i;

	// ------------------------------------------------------------
	// Blank as delivered; no reset so contents survive power cycles
	// ------------------------------------------------------------
	initial begin
		for (i = 0; i < (1<<AW); i = i + 1) begin
			mem[i] = {W{1'b0}};
		end
	end

	always @(posedge ref_clk) begin
		if (we) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end

endmodule // sgte_nvmem

// [design/sgte_flasher.v]
`timescale 1ns/1ps
`include "sgte_map.vh"

module sgte_flasher #(
	parameter FAST_HALF_CYC = `SGTE_FAST_HALF_NS / `SGTE_CLK_NS,
	parameter TICK_CYC      = `SGTE_TICK_MS * `SGTE_CYC_PER_MS
) (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       reset,
	// Pattern select and indicator
	input  wire [2:0] mode,
	output reg        led
);

	reg [31:0] fastCnt;
	reg        fastPh;
	reg [31:0] tickCnt;
	reg [4:0]  phase;

	// Burst of n flashes, 100 ms on and off, then dark to the second
	function burst;
		input [4:0] ph;
		input [4:0] n;
		begin
			burst = (ph[1] == 1'b0) && (ph < {n[2:0], 2'b00});
		end
	endfunction

	always @(posedge ref_clk) begin
		if (reset) begin
			fastCnt <= 32'h0;
			fastPh  <= 1'b0;
			tickCnt <= 32'h0;
			phase   <= 5'h0;
			led     <= 1'b0;
		end else begin
			fastCnt <= (fastCnt == FAST_HALF_CYC - 1) ? 32'h0 : fastCnt + 32'h1;
			if (fastCnt == FAST_HALF_CYC - 1) begin
				fastPh <= ~fastPh;
			end
			tickCnt <= (tickCnt == TICK_CYC - 1) ? 32'h0 : tickCnt + 32'h1;
			if (tickCnt == TICK_CYC - 1) begin
				phase <= (phase == `SGTE_TICKS_PER_S - 1) ? 5'h0 : phase + 5'h1;
			end
			case (mode)
				`SGTE_LED_ON:     led <= 1'b1;
				`SGTE_LED_FAST:   led <= fastPh;
				`SGTE_LED_SLOW:   led <= (phase < 5'h0a);
				`SGTE_LED_BURST3: led <= burst(phase, 5'h03);
				`SGTE_LED_BURST4: led <= burst(phase, 5'h04);
				default:          led <= 1'b0;
			endcase
		end
	end

endmodule // sgte_flasher

// [verif/sgte_eval_asserts.sv]
`timescale 1ns/1ps

module sgte_eval_asserts #(
	parameter READY_CYC     = 64,
	parameter FAST_HALF_CYC = 4
) (
	// Clock and reset
	input wire       ref_clk,
	input wire       reset,
	// Pins
	input wire [5:0] dipSwitch,
	input wire       startButton,
	input wire       functionTestInput,
	input wire       feedbackLoopB,
	input wire [3:0] headPresent,
	input wire       internalFault,
	// Outputs
	input wire       relayA,
	input wire       relayB,
	input wire       enableOutput,
	input wire       diagnosticOutput,
	input wire       ledState,
	input wire       ledOut,
	input wire       ledDia
);
	// ------------
	// Helpers
	// ------------
	reg [31:0] bootCnt;
	reg [31:0] stillCnt;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	always @(posedge ref_clk) begin
		if (reset)
			bootCnt <= 32'h0;
		else if (bootCnt < READY_CYC)
			bootCnt <= bootCnt + 32'h1;
	end

	// Cycles since the green indicator last changed
	always @(posedge ref_clk) begin
		if (reset || $changed(ledState))
			stillCnt <= 32'h0;
		else
			stillCnt <= stillCnt + 32'h1;
	end

	// ------------
	// Properties
	// ------------
	a_boot_open: assert property (bootCnt < READY_CYC |-> !relayA && !diagnosticOutput)
		else $error("output active during ready delay");
	a_boot_flash: assert property (bootCnt > 2 * FAST_HALF_CYC && bootCnt < READY_CYC - 2
		|-> stillCnt <= FAST_HALF_CYC + 1)
		else $error("green indicator not flashing fast in ready delay");
	a_fault_open: assert property (internalFault [*8] |-> !relayA && !relayB)
		else $error("relays closed during internal fault");
	a_door_open: assert property ((headPresent == 4'h0) [*8] |-> !relayA)
		else $error("relays closed with no actuator present");
	a_test_open: assert property (functionTestInput [*8] |-> !relayA && !relayB)
		else $error("relays closed during function test");
	a_manual_start: assert property ($rose(relayA) && dipSwitch[4] |-> $past(startButton, 8))
		else $error("manual mode closed without start press");
	a_loop_closed: assert property ($rose(relayA) && dipSwitch[5] |-> $past(feedbackLoopB, 2))
		else $error("closed with feedback loop open");
	a_relay_pair: assert property (relayA == relayB)
		else $error("relay outputs differ");
	a_yellow_led: assert property (ledOut == relayA && enableOutput == relayA)
		else $error("yellow indicator or enable not following relays");
	a_red_led: assert property (ledDia == diagnosticOutput)
		else $error("red indicator not following diagnostic output");

	c_manual_close: cover property ($rose(relayA) && dipSwitch[4]);
	c_test_diag: cover property (functionTestInput && diagnosticOutput);
	c_fault_open: cover property ($fell(relayA) && internalFault);
endmodule // sgte_eval_asserts

bind sgte_eval sgte_eval_asserts #(
	.READY_CYC    (READY_CYC),
	.FAST_HALF_CYC(FAST_HALF_CYC)
) chk (
	.ref_clk(ref_clk), .reset(reset), .dipSwitch(dipSwitch), .startButton(startButton),
	.functionTestInput(functionTestInput), .feedbackLoopB(feedbackLoopB), .headPresent(headPresent),
	.internalFault(internalFault), .relayA(relayA), .relayB(relayB), .enableOutput(enableOutput),
	.diagnosticOutput(diagnosticOutput), .ledState(ledState), .ledOut(ledOut), .ledDia(ledDia)
);

// [verif/sgte_operator_model.sv]
`timescale 1ns/1ps

module sgte_operator_model #(
	parameter CODE_W = 8
) (
	// Clock
	input  wire                ref_clk,
	// Scenario controls
	input  wire                jumperFitted,
	input  wire                loopConnected,
	input  wire                contactWelded,
	input  wire                codeSwapped,
	input  wire [3:0]          doorClosed,
	// Device terminals
	input  wire                teachJumperA,
	input  wire                feedbackLoopA,
	input  wire                relayA,
	input  wire                relayB,
	input  wire [3:0]          headActivate,
	output reg                 teachJumperB = 1'b0,
	output reg                 feedbackLoopB = 1'b0,
	output reg  [1:0]          relayContactOpen = 2'h3,
	output reg  [3:0]          headPresent = 4'h0,
	output reg  [4*CODE_W-1:0] headCode = {4*CODE_W{1'b0}}
);
	// ------------
	// Field side
	// ------------
	integer i;

	always @(posedge ref_clk) begin
		teachJumperB <= jumperFitted & teachJumperA;
		headPresent <= doorClosed;
		// A welded contact stays closed whatever the coil does
		relayContactOpen[0] <= ~relayA & ~contactWelded;
		relayContactOpen[1] <= ~relayB;
		// Loop runs through both break contacts, so it opens while either relay holds
		feedbackLoopB <= feedbackLoopA & loopConnected & ~relayA & ~relayB & ~contactWelded;
		for (i = 0; i < 4; i = i + 1) begin
			// An unpowered head inverts its last code every cycle, never holding a steady code
			if (headActivate[i])
				headCode[i*CODE_W +: CODE_W] <= CODE_W'(60 + 17 * i) ^ {CODE_W{codeSwapped}};
			else
				headCode[i*CODE_W +: CODE_W] <= ~headCode[i*CODE_W +: CODE_W];
		end
	end
endmodule // sgte_operator_model

// [verif/test_safety_gate_teach_eval.sv]
`timescale 1ns/1ps
`include "sgte_map.vh"

module test_safety_gate_teach_eval;
	// ------------
	// Bench state
	// ------------
	reg         ref_clk = 1'b0;
	reg         reset = 1'b1;
	reg         hsel = 1'b0;
	reg         hwrite = 1'b0;
	reg  [2:0]  hsize = 3'h0;
	reg  [1:0]  htrans = 2'h0;
	reg  [31:0] haddr = 32'h0;
	reg  [31:0] hwdata = 32'h0;
	reg  [5:0]  dipSwitch = 6'h23;
	reg  [3:0]  doorClosed = 4'h3;
	reg         startButton = 1'b0;
	reg         functionTestInput = 1'b0;
	reg         internalFault = 1'b0;
	reg         jumperFitted = 1'b0;
	reg         loopConnected = 1'b1;
	reg         contactWelded = 1'b0;
	reg         codeSwapped = 1'b0;
	reg  [31:0] rd;
	integer     badCount = 0;
	integer     checks = 0;
	integer     k;
	wire [31:0] hrdata, headCode;
	wire [3:0]  headPresent, headActivate;
	wire [1:0]  relayContactOpen;
	wire        hreadyout, hresp, teachJumperA, teachJumperB, feedbackLoopA, feedbackLoopB;
	wire        relayA, relayB, enableOutput, diagnosticOutput, ledState, ledOut, ledDia;

	always #2.5 ref_clk = ~ref_clk;

	sgte_eval #(.READY_CYC(64), .TEACH_CYC(100), .START_CYC(10), .SETTLE_CYC(8),
		.FAST_HALF_CYC(4)) dut (
		.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.teachJumperA(teachJumperA), .teachJumperB(teachJumperB), .dipSwitch(dipSwitch), .startButton(startButton),
		.functionTestInput(functionTestInput), .feedbackLoopA(feedbackLoopA), .feedbackLoopB(feedbackLoopB),
		.relayContactOpen(relayContactOpen), .headPresent(headPresent), .headCode(headCode),
		.headActivate(headActivate), .internalFault(internalFault), .relayA(relayA), .relayB(relayB),
		.enableOutput(enableOutput), .diagnosticOutput(diagnosticOutput), .ledState(ledState), .ledOut(ledOut),
		.ledDia(ledDia)
	);

	sgte_operator_model op (
		.ref_clk(ref_clk), .jumperFitted(jumperFitted), .loopConnected(loopConnected), .contactWelded(contactWelded),
		.codeSwapped(codeSwapped), .doorClosed(doorClosed), .teachJumperA(teachJumperA), .feedbackLoopA(feedbackLoopA),
		.relayA(relayA), .relayB(relayB), .headActivate(headActivate), .teachJumperB(teachJumperB),
		.feedbackLoopB(feedbackLoopB), .relayContactOpen(relayContactOpen), .headPresent(headPresent), .headCode(headCode)
	);

	// ------------
	// Tasks
	// ------------
	task tick(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask

	task check(input [31:0] got, input [31:0] exp, input [95:0] what);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				badCount = badCount + 1;
				$display("[ERR] %0t %0s: got %h, expected %h", $time, what, got, exp);
			end
		end
	endtask

	// Single word transfer; waits on hready at both phases, read data taken at the data-phase edge
	task busXfer(input wr, input [7:0] a, input [31:0] wd, output [31:0] d);
		begin
			@(posedge ref_clk);
			hsel <= 1'b1;
			haddr <= {24'h0, a};
			hwrite <= wr;
			hsize <= 3'h2;
			htrans <= 2'h2;
			@(posedge ref_clk);
			while (hreadyout !== 1'b1)
				@(posedge ref_clk);
			htrans <= 2'h0;
			hsel <= 1'b0;
			hwdata <= wd;
			@(posedge ref_clk);
			while (hreadyout !== 1'b1)
				@(posedge ref_clk);
			d = hrdata;
		end
	endtask

	task regCheck(input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			busXfer(1'b0, a, 32'h0, rd);
			check(rd & m, e, "register");
			check({31'h0, hresp}, 32'h0, "resp");
		end
	endtask

	task waitState(input [2:0] st);
		integer n;
		begin
			n = 0;
			busXfer(1'b0, `SGTE_OFS_STATUS, 32'h0, rd);
			while (rd[2:0] !== st && n < 400) begin
				n = n + 1;
				busXfer(1'b0, `SGTE_OFS_STATUS, 32'h0, rd);
			end
			check({29'h0, rd[2:0]}, {29'h0, st}, "state");
		end
	endtask

	// Polled at the falling edge so a relay update at the rising edge has landed
	task waitRelay(input v);
		integer n;
		begin
			n = 0;
			@(negedge ref_clk);
			while (relayA !== v && n < 200) begin
				n = n + 1;
				@(negedge ref_clk);
			end
			check({31'h0, relayA}, {31'h0, v}, "relay");
			@(posedge ref_clk);
		end
	endtask

	task boot(input j);
		begin
			@(posedge ref_clk);
			reset <= 1'b1;
			jumperFitted <= j;
			tick(10);
			reset <= 1'b0;
		end
	endtask

	task done(input [63:0] name);
		$display("test %0s done", name);
	endtask

	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks, badCount);
			if (badCount == 0 && checks > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	// ------------
	// Tests
	// ------------
	initial begin
		repeat (40000) @(posedge ref_clk);
		badCount = badCount + 1;
		complete_run;
	end

	initial begin
		boot(1'b0);
		regCheck(`SGTE_OFS_STATUS, 32'h1f, 32'h0);
		regCheck(`SGTE_OFS_CTRL, 32'hffffffff, 32'h0);
		regCheck(8'h0c, 32'hffffffff, 32'h0);
		waitState(3'h5);
		check({30'h0, relayA, ledDia}, 32'h1, "blank");
		done("blank");
		boot(1'b1);
		waitState(3'h1);
		check({28'h0, headActivate}, 32'hf, "activate");
		waitState(3'h3);
		tick(20);
		check({31'h0, ledState}, 32'h0, "ack");
		regCheck(`SGTE_OFS_CONFIG, 32'h7f, 32'h63);
		done("teach");
		boot(1'b0);
		waitState(3'h4);
		waitRelay(1'b1);
		regCheck(`SGTE_OFS_STATUS, 32'hf98, 32'h388);
		regCheck(`SGTE_OFS_CONFIG, 32'h7f, 32'h63);
		check({28'h0, headActivate}, 32'h3, "activate");
		check({29'h0, ledOut, enableOutput, relayB}, 32'h7, "yellow");
		done("run");
		functionTestInput <= 1'b1;
		tick(8);
		check({30'h0, relayA, diagnosticOutput}, 32'h1, "test on");
		regCheck(`SGTE_OFS_STATUS, 32'h38, 32'h30);
		functionTestInput <= 1'b0;
		tick(8);
		check({30'h0, diagnosticOutput, ledDia}, 32'h0, "test off");
		waitRelay(1'b1);
		done("test");
		for (k = 0; k < 3; k = k + 1) begin
			if (k == 0)
				doorClosed <= 4'h0;
			if (k == 1)
				codeSwapped <= 1'b1;
			if (k == 2)
				busXfer(1'b1, `SGTE_OFS_CTRL, 32'h1, rd);
			tick(10);
			check({31'h0, relayA}, 32'h0, "drop");
			doorClosed <= 4'h3;
			codeSwapped <= 1'b0;
			if (k == 2)
				busXfer(1'b1, `SGTE_OFS_CTRL, 32'h0, rd);
			waitRelay(1'b1);
		end
		done("drop");
		dipSwitch <= 6'h21;
		boot(1'b0);
		waitState(3'h5);
		dipSwitch <= 6'h23;
		boot(1'b0);
		waitRelay(1'b1);
		internalFault <= 1'b1;
		waitRelay(1'b0);
		waitState(3'h7);
		internalFault <= 1'b0;
		boot(1'b0);
		waitRelay(1'b1);
		contactWelded <= 1'b1;
		doorClosed <= 4'h0;
		waitState(3'h7);
		contactWelded <= 1'b0;
		doorClosed <= 4'h3;
		done("faults");
		dipSwitch <= 6'h13;
		loopConnected <= 1'b0;
		startButton <= 1'b1;
		boot(1'b1);
		waitState(3'h1);
		doorClosed <= 4'h1;
		waitState(3'h5);
		check({31'h0, ledDia}, 32'h1, "teach chg");
		doorClosed <= 4'h3;
		boot(1'b1);
		waitState(3'h3);
		startButton <= 1'b0;
		boot(1'b0);
		waitState(3'h4);
		tick(30);
		check({31'h0, relayA}, 32'h0, "no start");
		startButton <= 1'b1;
		waitRelay(1'b1);
		startButton <= 1'b0;
		regCheck(`SGTE_OFS_CONFIG, 32'h7f, 32'h53);
		done("manual");
		complete_run;
	end
endmodule // test_safety_gate_teach_eval
